// >>> alb_device.sv
/*
  analyser end: decodes the header, answers its own address with a
  signature word and the selected item set, latches a sample on trigger.
  assumes measurement inputs are on pclk; bus wires are asynchronous.
*/
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - answer only own address 0..14
// - master sends the target device address
// - item set chosen by mode 0..7
// - modes 0,1,5,6 item orders
// - mode 2: pressure, temp, aux, cooler
// - modes 3 and 4 item orders
// - broadcast trigger captures five-word sample
// - captured sample held until next trigger
// - every word shifted lsb first
// - diagnostic is one unsigned byte
// - bits 0..3 signal strength code
// - bit 4 sync always one
// - bit 5 wheel rate lock
// - bit 6 detector temperature ok
// - bit 7 chopper temperature ok
module alb_device #(
  parameter logic [31:0] SIGNATURE = 32'h00005A5A // arbitrary value
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // logger bus
  alb_if.device bus,
  // configuration
  input wire logic [3:0] own_addr,
  // measurements
  input wire logic [31:0] co2_density,
  input wire logic [31:0] h2o_density,
  input wire logic [31:0] co2_absorp,
  input wire logic [31:0] h2o_absorp,
  input wire logic [31:0] pressure,
  input wire logic [31:0] temperature,
  input wire logic [31:0] aux1,
  input wire logic [31:0] cooler,
  input wire logic [31:0] bandwidth,
  input wire logic [31:0] delay_interval,
  input wire logic [31:0] co2_sig_strength,
  // diagnostic sources
  input wire logic [3:0] sig_code,
  input wire logic pll_lock,
  input wire logic det_temp_ok,
  input wire logic chop_temp_ok
);
  typedef enum logic [3:0] {
    ALB_D_IDLE = 4'h1,
    ALB_D_HDR = 4'h2,
    ALB_D_SEND = 4'h4,
    ALB_D_WAIT = 4'h8
  } alb_dst_e;

  typedef struct packed {
    alb_dst_e st; // transfer state
    logic frame_m, frame_s; // frame synchroniser
    logic sclk_m, sclk_s, sclk_d; // clock synchroniser and edge history
    logic cmd_m, cmd_s; // header bit synchroniser
    logic [7:0] hdr; // header shift register
    logic [4:0] bitcnt; // bit position
    logic [3:0] widx; // word being sent, 0 is the signature
    logic [3:0] nwords; // words in this answer
    logic [2:0] mode; // latched item set
    logic [31:0] sh; // output shift register
    logic data; // driven bit
    logic oe; // drive enable
    logic [31:0] trig_cnt; // triggers seen
    logic [alb_pkg::SNAP_WORDS-1:0][31:0] snap; // held trigger sample
  } alb_dev_s;

  alb_dev_s s_r, s_nxt;
  logic [7:0] diag; // packed diagnostic byte

  // diagnostic byte assembly
  always_comb begin
    diag = '0;
    diag[alb_pkg::DG_SS_LSB +: 4] = sig_code;
    diag[alb_pkg::DG_SYNC] = 1'b1;
    diag[alb_pkg::DG_PLL] = pll_lock;
    diag[alb_pkg::DG_DET] = det_temp_ok;
    diag[alb_pkg::DG_CHOP] = chop_temp_ok;
  end

  // next state
  always_comb begin
    logic rise, fall;
    logic [7:0] h;
    logic [3:0] code;
    logic [31:0] val;
    rise = 1'b0;
    fall = 1'b0;
    h = '0;
    code = '0;
    val = '0;
    s_nxt = s_r;
    // synchronisers: first stage read only by second
    s_nxt.frame_m = bus.frame;
    s_nxt.frame_s = s_r.frame_m;
    s_nxt.sclk_m = bus.sclk;
    s_nxt.sclk_s = s_r.sclk_m;
    s_nxt.sclk_d = s_r.sclk_s;
    s_nxt.cmd_m = bus.cmd;
    s_nxt.cmd_s = s_r.cmd_m;
    rise = s_r.sclk_s & ~s_r.sclk_d;
    fall = ~s_r.sclk_s & s_r.sclk_d;
    h = {s_r.cmd_s, s_r.hdr[7:1]};
    // value of the next item to load
    code = alb_pkg::item_at(s_r.mode, s_r.widx);
    case (code)
      alb_pkg::IT_CO2D: val = co2_density;
      alb_pkg::IT_H2OD: val = h2o_density;
      alb_pkg::IT_CO2A: val = co2_absorp;
      alb_pkg::IT_H2OA: val = h2o_absorp;
      alb_pkg::IT_PRES: val = pressure;
      alb_pkg::IT_TEMP: val = temperature;
      alb_pkg::IT_AUX1: val = aux1;
      alb_pkg::IT_COOL: val = cooler;
      alb_pkg::IT_DIAG: val = {24'h000000, diag};
      alb_pkg::IT_BW: val = bandwidth;
      alb_pkg::IT_DLY: val = delay_interval;
      default: val = '0;
    endcase
    if (s_r.mode == alb_pkg::MODE_TRIG) begin
      // trigger mode reads the held sample only
      val = (s_r.widx < 4'(alb_pkg::SNAP_WORDS)) ? s_r.snap[s_r.widx[2:0]] : '0;
    end
    if (!s_r.frame_s) begin
      // no frame: release the line and rearm
      s_nxt.st = ALB_D_IDLE;
      s_nxt.oe = 1'b0;
      s_nxt.data = 1'b0;
      s_nxt.bitcnt = '0;
      s_nxt.hdr = '0;
    end else begin
      case (s_r.st)
        ALB_D_IDLE: begin
          s_nxt.st = ALB_D_HDR;
        end
        ALB_D_HDR: begin
          // collect header on rising edges
          if (rise) begin
            s_nxt.hdr = h;
            s_nxt.bitcnt = s_r.bitcnt + 5'h01;
            if (s_r.bitcnt == 5'(alb_pkg::HDR_BITS - 1)) begin
              s_nxt.bitcnt = '0;
              s_nxt.st = ALB_D_WAIT;
              if (h[alb_pkg::ADDR_LSB +: 4] == alb_pkg::ADDR_BCAST) begin
                // group trigger: latch a fresh sample set
                if (h[alb_pkg::MODE_LSB +: 3] == alb_pkg::MODE_TRIG) begin
                  s_nxt.trig_cnt = s_r.trig_cnt + 32'h00000001;
                  s_nxt.snap = {pressure, co2_sig_strength, h2o_density, co2_density,
                                s_r.trig_cnt + 32'h00000001};
                end
              end else if (h[alb_pkg::ADDR_LSB +: 4] == own_addr && own_addr <= alb_pkg::ADDR_MAX) begin
                // addressed: answer signature then items
                s_nxt.st = ALB_D_SEND;
                s_nxt.mode = h[alb_pkg::MODE_LSB +: 3];
                s_nxt.nwords = alb_pkg::item_count(h[alb_pkg::MODE_LSB +: 3]) + 4'h1;
                s_nxt.widx = '0;
                s_nxt.sh = SIGNATURE;
              end
            end
          end
        end
        ALB_D_SEND: begin
          // drive one bit per falling edge, lsb first
          if (fall) begin
            if (s_r.widx == s_r.nwords) begin
              s_nxt.oe = 1'b0;
              s_nxt.st = ALB_D_WAIT;
            end else begin
              s_nxt.oe = 1'b1;
              s_nxt.data = s_r.sh[0];
              s_nxt.sh = {1'b0, s_r.sh[31:1]};
              s_nxt.bitcnt = s_r.bitcnt + 5'h01;
              if (s_r.bitcnt == 5'(alb_pkg::WORD_BITS - 1)) begin
                s_nxt.bitcnt = '0;
                s_nxt.widx = s_r.widx + 4'h1;
                s_nxt.sh = val;
              end
            end
          end
        end
        ALB_D_WAIT: begin
          // idle until the frame ends
          s_nxt.oe = 1'b0;
        end
        default: begin
          s_nxt.st = ALB_D_IDLE;
          s_nxt.oe = 1'b0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= ALB_D_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.dev_data = s_r.data;
  assign bus.dev_oe = s_r.oe;
endmodule
`default_nettype wire

// >>> alb_pkg.sv
/*
  shared constants for the analyser logger bus: header layout, item codes,
  per-mode item tables and serial timing.
  assumes both ends run on the same 125 MHz pclk.
*/
package alb_pkg;
  // header: [3:0] target address, [6:4] item set select, [7] spare
  localparam int HDR_BITS = 8;
  localparam int ADDR_LSB = 0;
  localparam int MODE_LSB = 4;
  localparam logic [3:0] ADDR_MAX = 4'hE; // highest device address
  localparam logic [3:0] ADDR_BCAST = 4'hF; // broadcast address
  localparam logic [2:0] MODE_TRIG = 3'h7; // group trigger item set
  localparam int WORD_BITS = 32;
  localparam int MAX_ITEMS = 10;
  localparam int SNAP_WORDS = 5;
  // serial clock half period
  localparam int CLK_NS = 8;
  localparam int HALF_NS = 64;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
  // item codes
  localparam logic [3:0] IT_CO2D = 4'h0;
  localparam logic [3:0] IT_H2OD = 4'h1;
  localparam logic [3:0] IT_CO2A = 4'h2;
  localparam logic [3:0] IT_H2OA = 4'h3;
  localparam logic [3:0] IT_PRES = 4'h4;
  localparam logic [3:0] IT_TEMP = 4'h5;
  localparam logic [3:0] IT_AUX1 = 4'h6;
  localparam logic [3:0] IT_COOL = 4'h7;
  localparam logic [3:0] IT_DIAG = 4'h8;
  localparam logic [3:0] IT_BW = 4'h9;
  localparam logic [3:0] IT_DLY = 4'hA;
  // diagnostic byte fields
  localparam int DG_SS_LSB = 0;
  localparam int DG_SYNC = 4;
  localparam int DG_PLL = 5;
  localparam int DG_DET = 6;
  localparam int DG_CHOP = 7;
  // host registers
  localparam logic [11:0] RA_CTRL = 12'h000;
  localparam logic [11:0] RA_STATUS = 12'h004;
  localparam logic [11:0] RA_INT_STAT = 12'h008;
  localparam logic [11:0] RA_INT_MASK = 12'h00C;
  localparam logic [11:0] RA_SIG = 12'h010;
  localparam logic [11:0] RA_DATA = 12'h020;
  localparam int CTRL_GO = 8;

  // number of items each mode returns
  function automatic logic [3:0] item_count(input logic [2:0] m);
    case (m)
      3'h0, 3'h1: item_count = 4'h2;
      3'h2, 3'h6: item_count = 4'h4;
      3'h3, 3'h5: item_count = 4'h3;
      3'h4: item_count = 4'hA;
      default: item_count = 4'h5;
    endcase
  endfunction

  // item code at position i of mode m (mode 7 reads the snapshot instead)
  function automatic logic [3:0] item_at(input logic [2:0] m, input logic [3:0] i);
    logic [MAX_ITEMS-1:0][3:0] t;
    t = '0;
    case (m)
      3'h0: t[1:0] = {IT_H2OD, IT_CO2D};
      3'h1: t[1:0] = {IT_H2OA, IT_CO2A};
      3'h2: t[3:0] = {IT_COOL, IT_AUX1, IT_TEMP, IT_PRES};
      3'h3: t[2:0] = {IT_DLY, IT_BW, IT_DIAG};
      3'h4: t = {IT_DLY, IT_BW, IT_DIAG, IT_COOL, IT_TEMP, IT_PRES, IT_H2OA, IT_CO2A, IT_H2OD, IT_CO2D};
      3'h5: t[2:0] = {IT_PRES, IT_H2OD, IT_CO2D};
      3'h6: t[3:0] = {IT_DIAG, IT_PRES, IT_H2OD, IT_CO2D};
      default: t = '0;
    endcase
    item_at = (i < 4'(MAX_ITEMS)) ? t[i] : IT_CO2D;
  endfunction
endpackage

// >>> alb_if.sv
/*
  logger bus wires between one master and one analyser.
  assumes one device per interface instance; data_line resolves its single enable here.
*/
`timescale 1ns/1ns
`default_nettype none
interface alb_if;
  logic frame; // master: high for a whole transfer
  logic sclk; // master: serial clock
  logic cmd; // master: header bit, lsb first
  logic dev_data; // device: response bit
  logic dev_oe; // device: high while driving the data line
  logic data_line; // resolved data line, pulled low when undriven
  assign data_line = dev_oe & dev_data;
  modport master (output frame, output sclk, output cmd, input data_line);
  modport device (input frame, input sclk, input cmd, output dev_data, output dev_oe);
endinterface
`default_nettype wire

// >>> alb_master.sv
/*
  logger end: apb registers take a request (address, item set), shift the
  header out, collect signature and item words, raise a done interrupt.
  assumes one device per interface instance; data line is asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module alb_master (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // logger bus
  alb_if.master bus
);
  typedef enum logic [3:0] {
    ALB_M_IDLE = 4'h1,
    ALB_M_HDR = 4'h2,
    ALB_M_RESP = 4'h4,
    ALB_M_DONE = 4'h8
  } alb_mst_e;

  typedef struct packed {
    alb_mst_e st; // transfer state
    logic [3:0] div; // half period counter
    logic sclk, frame, cmd; // bus outputs
    logic [7:0] hdr; // header being sent
    logic [4:0] bitcnt; // bit position
    logic [3:0] widx, nwords; // word position and total
    logic [31:0] sh; // input shift register
    logic d_m, d_s; // data line synchroniser
    logic [alb_pkg::MAX_ITEMS-1:0][31:0] words; // received items
    logic [31:0] sig; // received signature
    logic int_stat, int_mask, irq; // done interrupt
    logic [31:0] prdata;
    logic pready, pslverr;
  } alb_mst_s;

  alb_mst_s s_r, s_nxt;

  // next state
  always_comb begin
    logic tick, acc, done_set;
    logic [11:0] wa;
    logic [3:0] di;
    tick = 1'b0;
    acc = 1'b0;
    done_set = 1'b0;
    wa = '0;
    di = '0;
    s_nxt = s_r;
    s_nxt.d_m = bus.data_line;
    s_nxt.d_s = s_r.d_m;
    tick = (s_r.div == alb_pkg::HALF_LAST);
    s_nxt.div = (s_r.st == ALB_M_IDLE || tick) ? 4'h0 : s_r.div + 4'h1;
    // serial engine
    case (s_r.st)
      ALB_M_IDLE: begin
        s_nxt.frame = 1'b0;
        s_nxt.sclk = 1'b0;
      end
      ALB_M_HDR: begin
        if (tick) begin
          s_nxt.sclk = ~s_r.sclk;
          if (s_r.sclk) begin
            s_nxt.bitcnt = s_r.bitcnt + 5'h01;
            s_nxt.cmd = s_r.hdr[s_r.bitcnt[2:0] + 3'h1];
            if (s_r.bitcnt == 5'(alb_pkg::HDR_BITS - 1)) begin
              s_nxt.bitcnt = '0;
              s_nxt.cmd = 1'b0;
              s_nxt.widx = '0;
              s_nxt.st = (s_r.hdr[alb_pkg::ADDR_LSB +: 4] == alb_pkg::ADDR_BCAST) ? ALB_M_DONE : ALB_M_RESP;
            end
          end
        end
      end
      ALB_M_RESP: begin
        if (tick) begin
          s_nxt.sclk = ~s_r.sclk;
          if (!s_r.sclk) begin
            s_nxt.sh = {s_r.d_s, s_r.sh[31:1]};
          end else begin
            s_nxt.bitcnt = s_r.bitcnt + 5'h01;
            if (s_r.bitcnt == 5'(alb_pkg::WORD_BITS - 1)) begin
              s_nxt.bitcnt = '0;
              s_nxt.widx = s_r.widx + 4'h1;
              if (s_r.widx == 4'h0) begin
                s_nxt.sig = s_r.sh;
              end else begin
                di = s_r.widx - 4'h1;
                s_nxt.words[di] = s_r.sh;
              end
              if (s_r.widx + 4'h1 == s_r.nwords) begin
                s_nxt.st = ALB_M_DONE;
              end
            end
          end
        end
      end
      ALB_M_DONE: begin
        // frame held one half period so the device lets go of the line first,
        // then low one half period before finishing
        s_nxt.sclk = 1'b0;
        if (tick) begin
          s_nxt.frame = 1'b0;
          if (!s_r.frame) begin
            s_nxt.st = ALB_M_IDLE;
            done_set = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = ALB_M_IDLE;
      end
    endcase
    // apb: no wait states, access completes on second cycle
    s_nxt.pready = psel & ~penable;
    acc = psel & penable & s_r.pready;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = '0;
    wa = paddr - alb_pkg::RA_DATA;
    if (psel & ~penable) begin
      case (paddr)
        alb_pkg::RA_CTRL: s_nxt.prdata = {24'h000000, s_r.hdr};
        alb_pkg::RA_STATUS: s_nxt.prdata = {31'h00000000, s_r.st != ALB_M_IDLE};
        alb_pkg::RA_INT_STAT: s_nxt.prdata = {31'h00000000, s_r.int_stat};
        alb_pkg::RA_INT_MASK: s_nxt.prdata = {31'h00000000, s_r.int_mask};
        alb_pkg::RA_SIG: s_nxt.prdata = s_r.sig;
        default: begin
          if (paddr >= alb_pkg::RA_DATA && wa[1:0] == 2'h0 && wa[11:2] < 10'(alb_pkg::MAX_ITEMS)) begin
            s_nxt.prdata = s_r.words[wa[5:2]];
          end else begin
            s_nxt.pslverr = 1'b1;
          end
        end
      endcase
    end
    // register writes
    if (acc & pwrite) begin
      case (paddr)
        alb_pkg::RA_CTRL: begin
          // start a request unless one is running
          if (pwdata[alb_pkg::CTRL_GO] && s_r.st == ALB_M_IDLE) begin
            s_nxt.hdr = {1'b0, pwdata[alb_pkg::MODE_LSB +: 3], pwdata[alb_pkg::ADDR_LSB +: 4]};
            s_nxt.nwords = alb_pkg::item_count(pwdata[alb_pkg::MODE_LSB +: 3]) + 4'h1;
            s_nxt.st = ALB_M_HDR;
            s_nxt.frame = 1'b1;
            s_nxt.sclk = 1'b0;
            s_nxt.cmd = pwdata[0];
            s_nxt.bitcnt = '0;
          end
        end
        alb_pkg::RA_INT_STAT: s_nxt.int_stat = s_r.int_stat & ~pwdata[0];
        alb_pkg::RA_INT_MASK: s_nxt.int_mask = pwdata[0];
        default: s_nxt.int_mask = s_r.int_mask;
      endcase
    end
    // set beats clear
    if (done_set) begin
      s_nxt.int_stat = 1'b1;
    end
    s_nxt.irq = s_nxt.int_stat & s_nxt.int_mask;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= ALB_M_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq = s_r.irq;
  assign bus.frame = s_r.frame;
  assign bus.sclk = s_r.sclk;
  assign bus.cmd = s_r.cmd;
endmodule
`default_nettype wire

// >>> alb_link_assertions.sv
/*
  checker for the logger bus wires between master and analyser.
  assumes every wire is sampled on pclk, reset async active low.
*/
`timescale 1ns/1ns
`default_nettype none
module alb_link_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bus wires
  input wire logic frame,
  input wire logic sclk,
  input wire logic cmd,
  input wire logic dev_data,
  input wire logic dev_oe,
  // device address
  input wire logic [3:0] own_addr
);
  logic sclk_r; // sclk one pclk ago
  logic [3:0] nrise_r; // sclk rises in this frame, saturating
  logic [7:0] hdr_r; // header bits seen so far
  logic rise_w; // sclk rising now
  logic match_w; // header names this device
  assign rise_w = sclk & ~sclk_r;
  assign match_w = (hdr_r[3:0] == own_addr) && (own_addr != 4'hF);
  // track sclk rises and collect the header lsb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_r <= 1'h0;
      nrise_r <= 4'h0;
      hdr_r <= 8'h00;
    end else begin
      sclk_r <= sclk;
      if (!frame) begin
        nrise_r <= 4'h0;
      end else if (rise_w && nrise_r < 4'h9) begin
        nrise_r <= nrise_r + 4'h1;
      end
      if (frame && rise_w && nrise_r < 4'h8) begin
        hdr_r[nrise_r[2:0]] <= cmd;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // first fall after a header addressed to this device
  sequence own_hdr_fall;
    frame && nrise_r == 4'h8 && match_w && sclk_r && !sclk;
  endsequence
  a_oe_in_frame: assert property (dev_oe |-> frame)
    else $error("device drives outside a frame");
  a_sclk_idle: assert property (!frame |-> !sclk)
    else $error("serial clock runs outside a frame");
  a_frame_gap: assert property ($fell(frame) |-> !frame [*8])
    else $error("frame gap too short");
  a_sclk_high: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high phase too short");
  a_cmd_steady: assert property ($rose(sclk) |-> $stable(cmd))
    else $error("header bit moves at sampling edge");
  a_hdr_spare: assert property (frame && rise_w && nrise_r == 4'h7 |-> !cmd)
    else $error("header spare bit set");
  a_no_answer: assert property (frame && nrise_r >= 4'h8 && !match_w |-> !dev_oe)
    else $error("device answers a foreign address");
  a_answer_soon: assert property (own_hdr_fall |-> ##[1:10] dev_oe)
    else $error("device does not answer own address");
  a_data_steady: assert property (dev_oe && $past(dev_oe) && $changed(dev_data) |-> !sclk)
    else $error("device data moves while serial clock high");
endmodule
`default_nettype wire

// >>> analyzer_logger_bus_output_test.sv
/*
  testbench: apb drives the master, which talks to the analyser.
  assumes both ends and the checker share pclk and presetn.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module analyzer_logger_bus_output_test;
  localparam logic [31:0] SIG_V = 32'hC3A50F96; // arbitrary signature value
  // item order per mode, one nibble per item, and item counts
  localparam logic [6:0][39:0] ORD = {40'h8410, 40'h410, 40'hA987543210, 40'hA98, 40'h7654, 40'h32, 40'h10};
  localparam logic [6:0][3:0] CNT = {4'h4, 4'h3, 4'hA, 4'h3, 4'h4, 4'h2, 4'h2};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, oe_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, sigw;
  logic [3:0] own_addr, sig_code;
  logic pll_lock, det_temp_ok, chop_temp_ok;
  logic [31:0] m [0:11]; // measurements by item code, 11 is signal strength
  logic [7:0] hdr;
  int failures, n_compared, hb, db;
  alb_if link();
  alb_master alb_master_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .bus(link.master));
  alb_device #(.SIGNATURE(SIG_V)) alb_device_i (.pclk(pclk), .presetn(presetn), .bus(link.device),
    .own_addr(own_addr), .co2_density(m[0]), .h2o_density(m[1]), .co2_absorp(m[2]), .h2o_absorp(m[3]),
    .pressure(m[4]), .temperature(m[5]), .aux1(m[6]), .cooler(m[7]), .bandwidth(m[9]),
    .delay_interval(m[10]), .co2_sig_strength(m[11]), .sig_code(sig_code), .pll_lock(pll_lock),
    .det_temp_ok(det_temp_ok), .chop_temp_ok(chop_temp_ok));
  alb_link_assertions alb_link_assertions_i (.pclk(pclk), .presetn(presetn), .frame(link.frame),
    .sclk(link.sclk), .cmd(link.cmd), .dev_data(link.dev_data), .dev_oe(link.dev_oe), .own_addr(own_addr));
  // clock
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  // wire monitor: header then first answer word, lsb first
  always @(posedge link.sclk) begin
    if (hb < 8) begin
      hdr[hb] = link.cmd;
      hb++;
    end else if (db < 32) begin
      sigw[db] = link.data_line;
      db++;
    end
  end
  always @(posedge pclk) if (link.dev_oe === 1'h1) oe_seen = 1'h1;
  // verdict
  task report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one apb transfer, waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'h1 && k < 16);
    if (pready !== 1'h1) begin failures++; report_and_stop(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'h0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  // start a bus transfer and wait until the master is idle
  task go(input logic [3:0] a, input logic [2:0] md);
    int k;
    hb = 0; db = 0; oe_seen = 1'h0;
    apb(1'h1, 12'h000, {23'h0, 1'h1, 1'h0, md, a});
    k = 0;
    do begin apb(1'h0, 12'h004, 32'h0); k++; end while (rd[0] !== 1'h0 && k < 3000);
    if (rd[0] !== 1'h0) begin failures++; report_and_stop(); end
    `CHK("header", {1'h0, md, a}, hdr)
    rd_chk(12'h000, {25'h0, md, a}, "ctrl header");
  endtask
  function automatic logic [31:0] exp_item(input logic [3:0] c);
    exp_item = (c == 4'h8) ? {24'h0, chop_temp_ok, det_temp_ok, pll_lock, 1'h1, sig_code} : m[c];
  endfunction
  // reset values and unmapped offsets
  task scn_regs;
    rd_chk(12'h004, 32'h0, "status");
    rd_chk(12'h008, 32'h0, "int status");
    rd_chk(12'h00C, 32'h0, "int mask");
    `CHK("irq idle", 1'h0, irq)
    apb(1'h0, 12'h100, 32'h0);
    `CHK("unmapped read err", 1'h1, er)
    `CHK("unmapped read data", 32'h0, rd)
    apb(1'h1, 12'h104, 32'h1);
    `CHK("unmapped write err", 1'h1, er)
  endtask
  // item sets 0 to 6 at the top address, diagnostic bits varied
  task scn_modes;
    for (int md = 0; md < 7; md++) begin
      sig_code <= 4'(2 * md + 1); pll_lock <= md[0]; det_temp_ok <= md[1]; chop_temp_ok <= md[2];
      go(4'hE, 3'(md));
      `CHK("signature wire", SIG_V, sigw)
      rd_chk(12'h010, SIG_V, "signature reg");
      for (int i = 0; i < CNT[md]; i++)
        rd_chk(12'(32'h20 + 4 * i), exp_item(ORD[md][4*i +: 4]), "item");
    end
  endtask
  // foreign addresses and the lowest address
  task scn_address;
    go(4'hD, 3'h0);
    `CHK("oe foreign", 1'h0, oe_seen)
    own_addr <= 4'h0;
    go(4'h0, 3'h5);
    `CHK("oe own", 1'h1, oe_seen)
    rd_chk(12'h020, m[0], "addr0 item");
    go(4'hE, 3'h5);
    `CHK("oe stale addr", 1'h0, oe_seen)
    own_addr <= 4'hE;
  endtask
  task chk7(input logic [31:0] c, input logic [31:0] a [0:11]);
    logic [31:0] e [0:4];
    e = '{c, a[0], a[1], a[11], a[4]};
    go(4'hE, 3'h7);
    for (int i = 0; i < 5; i++) rd_chk(12'(32'h20 + 4 * i), e[i], "held item");
  endtask
  // group trigger: sample held across changes until the next trigger
  task scn_trigger;
    logic [31:0] s [0:11];
    s = '{default: 32'h0};
    chk7(32'h0, s);
    go(4'hF, 3'h7);
    `CHK("oe broadcast", 1'h0, oe_seen)
    s = m;
    for (int i = 0; i < 12; i++) m[i] <= m[i] + 32'h01010101;
    // a broadcast of another item set must not capture
    go(4'hF, 3'h0);
    chk7(32'h1, s);
    go(4'hF, 3'h7);
    chk7(32'h2, m);
  endtask
  // done interrupt: masked, unmasked, cleared
  task scn_irq;
    apb(1'h1, 12'h008, 32'h1);
    rd_chk(12'h008, 32'h0, "int cleared");
    apb(1'h1, 12'h00C, 32'h1);
    go(4'hE, 3'h0);
    repeat (2) @(posedge pclk);
    `CHK("irq raised", 1'h1, irq)
    apb(1'h1, 12'h008, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq cleared", 1'h0, irq)
    apb(1'h1, 12'h00C, 32'h0);
    go(4'hE, 3'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq masked", 1'h0, irq)
    rd_chk(12'h008, 32'h1, "int set");
  endtask
  // main sequence
  initial begin
    failures = 0; n_compared = 0; hb = 8; db = 32; oe_seen = 1'h0;
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h0; pwdata = 32'h0;
    own_addr = 4'hE; sig_code = 4'h0; pll_lock = 1'h0; det_temp_ok = 1'h0; chop_temp_ok = 1'h0;
    for (int i = 0; i < 12; i++) m[i] = 32'(32'h9E3779B1 * (i + 1));
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    scn_regs;
    scn_modes;
    scn_address;
    scn_trigger;
    scn_irq;
    report_and_stop;
  end
endmodule
`default_nettype wire
